// File: hdl/redriver_ctrl_map.svh
// Constants of the redriver mode and strap control block.
// Assumes five-level pins arrive as 3-bit level codes from a level detector.
`ifndef REDRIVER_CTRL_MAP_SVH
`define REDRIVER_CTRL_MAP_SVH

// Five-level strap codes
`define LVL_L0 3'h0
`define LVL_L1 3'h1
`define LVL_L2 3'h2
`define LVL_L3 3'h3
`define LVL_L4 3'h4
`define LVL_W 3

// Timing of the block clock and of the EEPROM bus quarter bit
`define CLK_PERIOD_NS 100
`define BUS_QUARTER_NS 2500
`define BUS_QUARTER_CYC (`BUS_QUARTER_NS / `CLK_PERIOD_NS)
`define DIV_W 8

// EEPROM read: 7-bit device address, read flag, number of bytes loaded
`define EE_DEV_ADDR 7'h50
`define EE_READ_BIT 1'h1
`define EE_BYTES 8
`define EE_BYTE_W 4

// Cycles the strap synchronisers need before the power-up sample
`define STRAP_SETTLE 2'h3

`endif

// File: hdl/redriver_ctrl_pkg.sv
// Types shared by the redriver mode and strap control block.
// Assumes redriver_ctrl_map.svh is on the include path.
`include "redriver_ctrl_map.svh"

package redriver_ctrl_pkg;

	// Control source chosen by the mode strap
	typedef enum logic [1:0] {
		MODE_PIN,
		MODE_EEPROM,
		MODE_SECONDARY,
		MODE_RESERVED
	} ctrl_mode_t;

	// EEPROM loader sequence
	typedef enum logic [3:0] {
		LD_IDLE,
		LD_START,
		LD_ADDR,
		LD_ADDR_ACK,
		LD_READ,
		LD_MACK,
		LD_STOP,
		LD_DONE,
		LD_FAIL
	} ld_state_t;

	// Whole state of the control block
	typedef struct packed {
		logic [`LVL_W-1:0] mode_s1;
		logic [`LVL_W-1:0] mode_s2;
		logic [7*`LVL_W-1:0] strap_s1;
		logic [7*`LVL_W-1:0] strap_s2;
		logic [7*`LVL_W-1:0] strap_q;
		logic [1:0] settle;
		logic sampled;
		logic [1:0] pd_s1;
		logic [1:0] pd_s2;
		logic [1:0] pd_q;
		logic restart;
		logic ren_s1;
		logic ren_s2;
		logic scl_s1;
		logic scl_s2;
		logic sda_s1;
		logic sda_s2;
		ctrl_mode_t mode;
		ld_state_t ld;
		logic [`DIV_W-1:0] div;
		logic [1:0] quarter;
		logic [2:0] bitn;
		logic [`EE_BYTE_W-1:0] bytn;
		logic [7:0] shreg;
		logic [`EE_BYTES*8-1:0] cfg;
		logic fail;
		logic scl_low;
		logic sda_low;
	} ctrl_state_t;

endpackage

// File: hdl/redriver_mode_and_strap_control.sv
// Mode strap decode, power-up strap capture, EEPROM loader and power-down
// control of an eight-channel redriver.
// Assumes all pins are asynchronous to mclk_i and that an external
// secondary engine answers on the bus while secondary_enable_o is high.
`timescale 1ns/1ps
`include "redriver_ctrl_map.svh"

module redriver_mode_and_strap_control
	import redriver_ctrl_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [`LVL_W-1:0] mode_level_i,
	input wire logic [`LVL_W-1:0] eq_or_bus_addr_strap_a_i,
	input wire logic [`LVL_W-1:0] eq_or_bus_addr_strap_b_i,
	input wire logic [`LVL_W-1:0] upper_bank_boost_strap_a_i,
	input wire logic [`LVL_W-1:0] upper_bank_boost_strap_b_i,
	input wire logic [`LVL_W-1:0] lower_bank_flat_gain_level_i,
	input wire logic [`LVL_W-1:0] upper_bank_flat_gain_strap_i,
	input wire logic [`LVL_W-1:0] rxdetect_strap_level_i,
	input wire logic lower_bank_powerdown_i,
	input wire logic upper_bank_powerdown_i,
	input wire logic read_en_n_i,
	input wire logic rxdetect_strap_or_bus_clock_i,
	input wire logic lower_bank_flat_gain_or_bus_data_i,
	output logic rxdetect_strap_or_bus_clock_o,
	output logic rxdetect_strap_or_bus_clock_oe_n_o,
	output logic lower_bank_flat_gain_or_bus_data_o,
	output logic lower_bank_flat_gain_or_bus_data_oe_n_o,
	output logic load_done_n_o,
	output logic load_done_n_oe_n_o,
	output logic mode_pin_o,
	output logic mode_eeprom_o,
	output logic mode_secondary_o,
	output logic mode_reserved_o,
	output logic secondary_enable_o,
	output logic strap_cfg_valid_o,
	output logic [`LVL_W-1:0] bus_addr_a_o,
	output logic [`LVL_W-1:0] bus_addr_b_o,
	output logic [`LVL_W-1:0] upper_boost_a_o,
	output logic [`LVL_W-1:0] upper_boost_b_o,
	output logic [`LVL_W-1:0] lower_flat_gain_o,
	output logic [`LVL_W-1:0] upper_flat_gain_o,
	output logic [`LVL_W-1:0] rxdetect_strap_o,
	output logic [`EE_BYTES*8-1:0] eeprom_cfg_o,
	output logic eeprom_cfg_valid_o,
	output logic signal_path_enable_o,
	output logic lower_bank_powerdown_o,
	output logic upper_bank_powerdown_o,
	output logic rxdetect_restart_o
);

	localparam logic [`DIV_W-1:0] QUARTER_LAST =
		`DIV_W'(`BUS_QUARTER_CYC - 1);
	localparam logic [`EE_BYTE_W-1:0] LAST_BYTE =
		`EE_BYTE_W'(`EE_BYTES - 1);
	localparam logic [7:0] ADDR_BYTE = {`EE_DEV_ADDR, `EE_READ_BIT};

	ctrl_state_t s;
	ctrl_state_t n;
	logic tick;
	logic serial_mode;
	logic loading;

	// Quarter-bit enable for the EEPROM bus
	assign tick = (s.div == QUARTER_LAST);
	assign serial_mode = (s.mode == MODE_EEPROM) || (s.mode == MODE_SECONDARY);
	assign loading = (s.ld != LD_IDLE) && (s.ld != LD_DONE) &&
		(s.ld != LD_FAIL);

	// Next state of the whole block
	always_comb begin
		n = s;
		n.restart = 1'b0;

		// Two-flop synchronisers on every pin
		n.mode_s1 = mode_level_i;
		n.mode_s2 = s.mode_s1;
		n.strap_s1 = {eq_or_bus_addr_strap_a_i, eq_or_bus_addr_strap_b_i,
			upper_bank_boost_strap_a_i, upper_bank_boost_strap_b_i,
			lower_bank_flat_gain_level_i, upper_bank_flat_gain_strap_i,
			rxdetect_strap_level_i};
		n.strap_s2 = s.strap_s1;
		n.pd_s1 = {upper_bank_powerdown_i, lower_bank_powerdown_i};
		n.pd_s2 = s.pd_s1;
		n.ren_s1 = read_en_n_i;
		n.ren_s2 = s.ren_s1;
		n.scl_s1 = rxdetect_strap_or_bus_clock_i;
		n.scl_s2 = s.scl_s1;
		n.sda_s1 = lower_bank_flat_gain_or_bus_data_i;
		n.sda_s2 = s.sda_s1;

		// One power-up sample of the straps, then held
		// Waits until both synchroniser flops carry real pin levels
		if (!s.sampled) begin
			if (s.settle == `STRAP_SETTLE) begin
				n.strap_q = s.strap_s2;
				n.sampled = 1'b1;
			end else begin
				n.settle = s.settle + 2'h1;
			end
		end

		// Power-down levels; any toggle restarts receiver detect
		n.pd_q = s.pd_s2;
		if (s.pd_q != s.pd_s2) begin
			n.restart = 1'b1;
		end

		// Mode strap followed continuously, not just at power-up
		case (s.mode_s2)
			`LVL_L0: n.mode = MODE_PIN;
			`LVL_L1: n.mode = MODE_EEPROM;
			`LVL_L2: n.mode = MODE_SECONDARY;
			default: n.mode = MODE_RESERVED;
		endcase

		// Quarter-bit divider runs only while the loader is busy
		// Cleared in idle so every frame opens on a full quarter
		if (loading && !tick) begin
			n.div = s.div + `DIV_W'(1);
		end else begin
			n.div = '0;
		end
		if (loading && tick) begin
			n.quarter = s.quarter + 2'h1;
		end

		// EEPROM loader; quarters: 0 low, 1-2 high, 3 low
		case (s.ld)
			LD_IDLE: begin
				n.quarter = 2'h0;
				n.scl_low = 1'b0;
				n.sda_low = 1'b0;
				n.fail = 1'b0;
				// Read-enable only looked at in EEPROM mode, bus idle
				// Mode decode lags the read-enable flops by one edge, so the
				// synchronised level must still say L1 as well
				if (s.mode == MODE_EEPROM && s.mode_s2 == `LVL_L1 &&
					s.sampled && !s.ren_s2 && s.scl_s2 && s.sda_s2) begin
					n.ld = LD_START;
				end
			end
			LD_START: begin
				if (tick) begin
					case (s.quarter)
						2'h1: n.sda_low = 1'b1;
						2'h2: n.scl_low = 1'b1;
						2'h3: begin
							n.shreg = ADDR_BYTE;
							n.bitn = 3'h7;
							n.sda_low = ~ADDR_BYTE[7];
							n.ld = LD_ADDR;
						end
						default: n.scl_low = 1'b0;
					endcase
				end
			end
			LD_ADDR: begin
				if (tick) begin
					case (s.quarter)
						2'h0: n.scl_low = 1'b0;
						2'h1: begin
							// Another primary pulled data low: back off
							if (!s.sda_low && !s.sda_s2) begin
								n.ld = LD_IDLE;
							end
						end
						2'h2: n.scl_low = 1'b1;
						default: begin
							if (s.bitn == 3'h0) begin
								n.sda_low = 1'b0;
								n.ld = LD_ADDR_ACK;
							end else begin
								n.shreg = {s.shreg[6:0], 1'b0};
								n.sda_low = ~s.shreg[6];
								n.bitn = s.bitn - 3'h1;
							end
						end
					endcase
				end
			end
			// Missing acknowledge ends the frame with a stop, then fail
			LD_ADDR_ACK: begin
				if (tick) begin
					case (s.quarter)
						2'h0: n.scl_low = 1'b0;
						2'h1: n.fail = s.sda_s2;
						2'h2: n.scl_low = 1'b1;
						default: begin
							n.bitn = 3'h7;
							n.bytn = '0;
							n.sda_low = s.fail;
							n.ld = s.fail ? LD_STOP : LD_READ;
						end
					endcase
				end
			end
			// Data taken in the middle of the high phase, past the synchroniser delay
			LD_READ: begin
				if (tick) begin
					case (s.quarter)
						2'h0: n.scl_low = 1'b0;
						2'h1: n.shreg = {s.shreg[6:0], s.sda_s2};
						2'h2: n.scl_low = 1'b1;
						default: begin
							if (s.bitn == 3'h0) begin
								n.cfg[s.bytn*8 +: 8] = s.shreg;
								// Acknowledge all but the last byte
								n.sda_low = (s.bytn != LAST_BYTE);
								n.ld = LD_MACK;
							end else begin
								n.bitn = s.bitn - 3'h1;
							end
						end
					endcase
				end
			end
			// Primary acknowledge after each byte, not after the last
			LD_MACK: begin
				if (tick) begin
					case (s.quarter)
						2'h0: n.scl_low = 1'b0;
						2'h2: n.scl_low = 1'b1;
						2'h3: begin
							if (s.bytn == LAST_BYTE) begin
								n.sda_low = 1'b1;
								n.ld = LD_STOP;
							end else begin
								n.sda_low = 1'b0;
								n.bitn = 3'h7;
								n.bytn = s.bytn + `EE_BYTE_W'(1);
								n.ld = LD_READ;
							end
						end
						default: n.scl_low = 1'b0;
					endcase
				end
			end
			// Data rises while the clock is high to close the frame
			LD_STOP: begin
				if (tick) begin
					case (s.quarter)
						2'h0: n.scl_low = 1'b0;
						2'h1: n.sda_low = 1'b0;
						2'h3: n.ld = s.fail ? LD_FAIL : LD_DONE;
						default: n.sda_low = 1'b0;
					endcase
				end
			end
			LD_DONE: begin
				// Read-enable may stay low; nothing more happens
				n.scl_low = 1'b0;
				n.sda_low = 1'b0;
			end
			LD_FAIL: begin
				n.scl_low = 1'b0;
				n.sda_low = 1'b0;
			end
			default: n.ld = LD_IDLE;
		endcase

		// Leaving EEPROM mode abandons the load and frees the bus
		if (s.mode != MODE_EEPROM) begin
			n.ld = LD_IDLE;
			n.scl_low = 1'b0;
			n.sda_low = 1'b0;
		end
	end

	// State register
	// Reset stands for power-up; every field restarts from a constant
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '{mode: MODE_RESERVED, ld: LD_IDLE, default: '0};
		end else begin
			s <= n;
		end
	end

	// Mode flags and secondary enable
	// Reserved levels: no bus and done released as in strap mode, but strap_cfg_valid_o stays low
	assign mode_pin_o = (s.mode == MODE_PIN);
	assign mode_eeprom_o = (s.mode == MODE_EEPROM);
	assign mode_secondary_o = (s.mode == MODE_SECONDARY);
	assign mode_reserved_o = (s.mode == MODE_RESERVED);
	assign secondary_enable_o = serial_mode;

	// Power-up strap values, held until the next reset
	assign strap_cfg_valid_o = s.sampled && (s.mode == MODE_PIN);
	assign bus_addr_a_o = s.strap_q[7*`LVL_W-1 -: `LVL_W];
	assign bus_addr_b_o = s.strap_q[6*`LVL_W-1 -: `LVL_W];
	assign upper_boost_a_o = s.strap_q[5*`LVL_W-1 -: `LVL_W];
	assign upper_boost_b_o = s.strap_q[4*`LVL_W-1 -: `LVL_W];
	assign lower_flat_gain_o = s.strap_q[3*`LVL_W-1 -: `LVL_W];
	assign upper_flat_gain_o = s.strap_q[2*`LVL_W-1 -: `LVL_W];
	assign rxdetect_strap_o = s.strap_q[`LVL_W-1:0];

	// Loaded configuration
	assign eeprom_cfg_o = s.cfg;
	assign eeprom_cfg_valid_o = (s.ld == LD_DONE);

	// Path is off while the EEPROM load runs
	assign signal_path_enable_o = s.sampled && !loading;
	assign lower_bank_powerdown_o = s.pd_q[0];
	assign upper_bank_powerdown_o = s.pd_q[1];
	assign rxdetect_restart_o = s.restart;

	// Open-drain pins: output held low, enable low pulls the wire down
	// Only the enables move, so a pin is never driven high
	assign rxdetect_strap_or_bus_clock_o = 1'b0;
	assign rxdetect_strap_or_bus_clock_oe_n_o = ~s.scl_low;
	assign lower_bank_flat_gain_or_bus_data_o = 1'b0;
	assign lower_bank_flat_gain_or_bus_data_oe_n_o = ~s.sda_low;
	assign load_done_n_o = 1'b0;
	// Pulled low only on success in EEPROM mode, released otherwise
	assign load_done_n_oe_n_o = ~((s.mode == MODE_EEPROM) &&
		(s.ld == LD_DONE));

endmodule

// File: sim/redriver_ctrl_assertions.sv
// Checker of mode decode, load-done, path and power-down ports.
// Assumes it is bound to the control block and sees only its ports.
`timescale 1ns/1ps
`include "redriver_ctrl_map.svh"
module redriver_ctrl_assertions (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [`LVL_W-1:0] mode_level_i,
	input wire logic lower_bank_powerdown_i,
	input wire logic upper_bank_powerdown_i,
	input wire logic rxdetect_strap_or_bus_clock_oe_n_o,
	input wire logic load_done_n_oe_n_o,
	input wire logic mode_pin_o,
	input wire logic mode_eeprom_o,
	input wire logic mode_secondary_o,
	input wire logic eeprom_cfg_valid_o,
	input wire logic signal_path_enable_o,
	input wire logic lower_bank_powerdown_o,
	input wire logic upper_bank_powerdown_o,
	input wire logic rxdetect_restart_o
);
	// Power-down levels of both banks, input and output side
	wire [1:0] pd_in = {upper_bank_powerdown_i, lower_bank_powerdown_i};
	wire [1:0] pd_out = {upper_bank_powerdown_o, lower_bank_powerdown_o};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	pin_mode_a: assert property (
		(mode_level_i == `LVL_L0) [*5] |-> mode_pin_o) else $error("pin mode");
	eeprom_mode_a: assert property (
		(mode_level_i == `LVL_L1) [*5] |-> mode_eeprom_o) else $error("ee mode");
	secondary_mode_a: assert property (
		(mode_level_i == `LVL_L2) [*5] |-> mode_secondary_o)
		else $error("secondary mode");
	no_load_a: assert property (
		(mode_level_i != `LVL_L1) [*6] |->
		load_done_n_oe_n_o && rxdetect_strap_or_bus_clock_oe_n_o)
		else $error("bus or done driven outside load mode");
	path_off_a: assert property (
		!rxdetect_strap_or_bus_clock_oe_n_o |-> !signal_path_enable_o)
		else $error("path on while loading");
	done_flag_a: assert property (
		!load_done_n_oe_n_o == (eeprom_cfg_valid_o && mode_eeprom_o))
		else $error("done flag");
	pd_follow_a: assert property (
		$stable(pd_in) [*4] |-> pd_out == pd_in) else $error("power-down");
	restart_a: assert property (
		rxdetect_restart_o == (pd_out != $past(pd_out)))
		else $error("restart pulse");
endmodule
bind redriver_mode_and_strap_control redriver_ctrl_assertions i_chk (.*);

// File: sim/eeprom_model.sv
// Behavioural EEPROM on the two-wire bus answering one sequential read.
// Assumes wired-AND bus levels with pull-ups at its inputs.
`timescale 1ns/1ps
module eeprom_model (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic ack_en_i,
	input wire logic [63:0] mem_i,
	output logic oe_n_o
);
	int bitc = 0;
	int byn = 0;
	logic act = 0;
	logic rd = 0;
	logic [7:0] sh = 8'h00;
	initial oe_n_o = 1'h1;
	// Start opens a frame, stop closes it
	always @(negedge sda_i) if (scl_i) begin
		act = 1'h1;
		bitc = 0;
		rd = 1'h0;
		byn = 0;
	end
	always @(posedge sda_i) if (scl_i) act = 1'h0;
	// Address shift and acknowledge taking on clock rise
	always @(posedge scl_i) if (act) begin
		if (bitc == 8 && rd) begin
			act = !sda_i;
			byn = byn + 1;
		end else if (bitc == 8) begin
			rd = !oe_n_o;
			act = rd;
		end else if (!rd) sh = {sh[6:0], sda_i};
		bitc = (bitc == 8) ? 0 : bitc + 1;
	end
	// Acknowledge or data bit driven while the clock is low
	always @(negedge scl_i) if (act) begin
		if (bitc == 8) oe_n_o = rd || !ack_en_i || sh != 8'hA1;
		else oe_n_o = !rd || mem_i[8 * byn + 7 - bitc];
	end
endmodule

// File: sim/tb_redriver_mode_and_strap_control.sv
// Bench of the redriver control block against a bench reference.
// Assumes the checker binds itself and both bus wires have pull-ups.
`timescale 1ns/1ps
`include "redriver_ctrl_map.svh"
module tb_redriver_mode_and_strap_control;
	localparam logic [11:0] pd_seq = 12'h68D;
	logic mclk_i = 0, rst_n_i = 0, read_en_n_i = 1, ack_en = 1, ext_scl = 1;
	logic lower_bank_powerdown_i = 0, upper_bank_powerdown_i = 0, ext_on = 0;
	logic [`LVL_W-1:0] mode_level_i = `LVL_L0;
	logic [7*`LVL_W-1:0] st, st0;
	logic [63:0] mem;
	logic [7:0] ref_q[$];
	logic [31:0] rs = 32'h0D3435E8;
	wire [7*`LVL_W-1:0] lt;
	wire [3:0] fl;
	wire [63:0] cfg;
	wire scl_oe_n, sda_oe_n, ee_oe_n, done_n, sec_en, sv, cfg_ok, path;
	wire pd0, pd1, restart;
	wire [2:0] lo;
	wire scl = scl_oe_n & ext_scl;
	wire sda = sda_oe_n & ee_oe_n;
	int mismatches = 0, n_checks = 0, pulses = 0, pulls = 0;
	redriver_mode_and_strap_control i_redriver_mode_and_strap_control (
		.mclk_i, .rst_n_i, .mode_level_i, .read_en_n_i,
		.lower_bank_powerdown_i, .upper_bank_powerdown_i,
		.eq_or_bus_addr_strap_a_i(st[20:18]),
		.eq_or_bus_addr_strap_b_i(st[17:15]),
		.upper_bank_boost_strap_a_i(st[14:12]),
		.upper_bank_boost_strap_b_i(st[11:9]),
		.lower_bank_flat_gain_level_i(st[8:6]),
		.upper_bank_flat_gain_strap_i(st[5:3]),
		.rxdetect_strap_level_i(st[2:0]),
		.rxdetect_strap_or_bus_clock_i(scl),
		.lower_bank_flat_gain_or_bus_data_i(sda),
		.rxdetect_strap_or_bus_clock_o(lo[0]),
		.rxdetect_strap_or_bus_clock_oe_n_o(scl_oe_n),
		.lower_bank_flat_gain_or_bus_data_o(lo[1]),
		.lower_bank_flat_gain_or_bus_data_oe_n_o(sda_oe_n),
		.load_done_n_o(lo[2]), .load_done_n_oe_n_o(done_n),
		.mode_pin_o(fl[0]), .mode_eeprom_o(fl[1]),
		.mode_secondary_o(fl[2]), .mode_reserved_o(fl[3]),
		.secondary_enable_o(sec_en), .strap_cfg_valid_o(sv),
		.bus_addr_a_o(lt[20:18]), .bus_addr_b_o(lt[17:15]),
		.upper_boost_a_o(lt[14:12]), .upper_boost_b_o(lt[11:9]),
		.lower_flat_gain_o(lt[8:6]), .upper_flat_gain_o(lt[5:3]),
		.rxdetect_strap_o(lt[2:0]), .eeprom_cfg_o(cfg),
		.eeprom_cfg_valid_o(cfg_ok), .signal_path_enable_o(path),
		.lower_bank_powerdown_o(pd0), .upper_bank_powerdown_o(pd1),
		.rxdetect_restart_o(restart));
	eeprom_model i_eeprom_model (.scl_i(scl), .sda_i(sda),
		.ack_en_i(ack_en), .mem_i(mem), .oe_n_o(ee_oe_n));
	// Block clock, and an outside primary's bus clock only in its frame
	// The outside primary stays off the bus while the load runs
	initial forever #50 mclk_i = ~mclk_i;
	always #400 ext_scl = ext_on ? !ext_scl : 1'h1;
	// Restart pulses and bus clock pulls by the block
	always @(posedge mclk_i) begin
		pulses += restart;
		pulls += !scl_oe_n;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [20:0] straps();
		logic [20:0] v;
		for (int i = 0; i < 7; i++) begin
			rs = lfsr(rs);
			v[3*i+:3] = 3'(rs % 5);
		end
		return v;
	endfunction
	task chk(input string n, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog well past the expected run of some 12500 cycles
	initial begin
		#3000000;
		mismatches++;
		conclude();
	end
	// Main sequence
	initial begin
		st = straps();
		st0 = st;
		mem = {lfsr(rs), lfsr(lfsr(rs))};
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'h1;
		cyc(8);
		chk("strap", lt, st0);
		chk("pin", {done_n, sv, path}, 3'h7);
		chk("low", lo, 3'h0);
		@(posedge mclk_i) st <= straps();
		cyc(8);
		chk("held", lt, st0);
		// Every mode level; read-enable held inactive only in load mode
		for (int l = 0; l < 5; l++) begin
			@(posedge mclk_i) begin
				mode_level_i <= 3'(l);
				read_en_n_i <= (l == 1);
				ext_on <= (l == 2);
			end
			cyc(6);
			pulls = 0;
			cyc(150);
			chk("mode", {sec_en, sv, fl},
				{l == 1 || l == 2, l == 0, 4'(1 << (l < 3 ? l : 3))});
			chk("no_load", {pulls, done_n}, 1);
		end
		// Power-down steps, two of them changing both banks at once
		for (int t = 0; t < 6; t++) begin
			pulses = 0;
			@(posedge mclk_i) begin
				{upper_bank_powerdown_i, lower_bank_powerdown_i} <= pd_seq[2*t+:2];
			end
			cyc(6);
			chk("pd", {pd1, pd0}, pd_seq[2*t+:2]);
			chk("pulses", pulses, t != 4);
		end
		// EEPROM load, read-enable kept low after completion
		for (int k = 0; k < `EE_BYTES; k++) begin
			ref_q.push_back(mem[8*k+:8]);
		end
		@(posedge mclk_i) begin
			mode_level_i <= `LVL_L1;
			read_en_n_i <= 1'h0;
		end
		cyc(2000);
		chk("loading", {path, sec_en, done_n}, 3'h3);
		for (int i = 0; i < 12000 && done_n !== 1'h0; i++) cyc(1);
		chk("cfg", cfg, mem);
		for (int k = 0; k < `EE_BYTES; k++) begin
			chk("byte", cfg[8*k+:8], ref_q.pop_front());
		end
		chk("done", {cfg_ok, path}, 2'h3);
		cyc(300);
		chk("stays", done_n, 0);
		// Unanswered address: load fails and done stays released
		@(posedge mclk_i) begin
			mode_level_i <= `LVL_L0;
			ack_en <= 1'h0;
		end
		cyc(10);
		chk("abort", done_n, 1);
		@(posedge mclk_i) mode_level_i <= `LVL_L1;
		cyc(3000);
		chk("fail", {done_n, cfg_ok, path}, 3'h5);
		conclude();
	end
endmodule
